// ---- hdl/ccl_pkg.sv ----
// Package of register offsets, field positions and reset values for the comparator control.
package ccl_pkg;

    // ------------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] CCL_OFS_CONTROL   = 8'h00;
    localparam logic [7:0] CCL_OFS_IRQ_STAT  = 8'h04;
    localparam logic [7:0] CCL_OFS_IRQ_MASK  = 8'h08;

    // ------------------------------------------------------------------
    // Control register field positions
    // ------------------------------------------------------------------
    localparam int CCL_BIT_ENABLE     = 15;
    localparam int CCL_BIT_PIN_DRIVE  = 14;
    localparam int CCL_BIT_INVERT     = 13;
    localparam int CCL_BIT_RESULT     = 8;
    localparam int CCL_BIT_EDGE_HI    = 7;
    localparam int CCL_BIT_EDGE_LO    = 6;
    localparam int CCL_BIT_POS_SEL    = 4;
    localparam int CCL_BIT_NEG_HI     = 1;
    localparam int CCL_BIT_NEG_LO     = 0;

    // Writable bits of the control register; everything else except the result bit reads zero.
    localparam logic [31:0] CCL_CONTROL_WMASK = 32'h0000_E0D3;
    // Control value after reset: edge select 11, negative select 11.
    localparam logic [31:0] CCL_CONTROL_RESET = 32'h0000_00C3;

    // ------------------------------------------------------------------
    // Interrupt status and mask layout
    // ------------------------------------------------------------------
    localparam int          CCL_BIT_IRQ_EDGE   = 0;
    localparam logic [31:0] CCL_IRQ_WMASK      = 32'h0000_0001;
    localparam logic [31:0] CCL_IRQ_RESET      = 32'h0000_0000;

    // ------------------------------------------------------------------
    // Field encodings
    // ------------------------------------------------------------------
    localparam logic [1:0] CCL_EDGE_NONE    = 2'h0;
    localparam logic [1:0] CCL_EDGE_RISE    = 2'h1;
    localparam logic [1:0] CCL_EDGE_FALL    = 2'h2;
    localparam logic [1:0] CCL_EDGE_BOTH    = 2'h3;

    localparam logic [1:0] CCL_NEG_PIN_B    = 2'h0;
    localparam logic [1:0] CCL_NEG_PIN_C    = 2'h1;
    localparam logic [1:0] CCL_NEG_PIN_D    = 2'h2;
    localparam logic [1:0] CCL_NEG_BANDGAP  = 2'h3;

endpackage

// ---- hdl/ccl_edge_detect.sv ----
// Edge detector that turns a synchronised result into single-cycle event pulses.
`timescale 1ns/10ps

module ccl_edge_detect
    import ccl_pkg::*;
(
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // Sampled level and edge selection
    input  wire logic       level_i,
    input  wire logic [1:0] edge_sel_i,
    // Event output
    output logic            event_o
);

    logic prev_q;
    logic rise;
    logic fall;

    // ------------------------------------------------------------------
    // Edge qualification
    // ------------------------------------------------------------------
    // Compare consecutive samples; a qualifying edge gives one pulse.
    assign rise    = level_i & ~prev_q;
    assign fall    = ~level_i & prev_q;
    assign event_o = (edge_sel_i == CCL_EDGE_RISE) ? rise :        // see [R5]
                     (edge_sel_i == CCL_EDGE_FALL) ? fall :
                     (edge_sel_i == CCL_EDGE_BOTH) ? (rise | fall) : 1'b0;  // see [R11]

    // The previous sample resets low, so a high level at release looks like a rise.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= level_i;
        end
    end

endmodule

// ---- hdl/ccl_top.sv ----
// Comparator control and event logic with a classic Wishbone register slave.
//
// Function
// [R1] Enable bit toggles only comparator function
// [R2] Drive-enable bit puts result on pin
// [R3] Invert bit inverts presented result
// [R4] Read-only result status, resets zero
// [R5] Edge field: none, rise, fall, both
// [R6] Inversion also feeds the edge detector
// [R7] Positive select: reference or pin A
// [R8] Negative select: pins B, C, D, band-gap
// [R9] Unimplemented control bits read zero
// [R10] Software avoids access right after disable
// [R11] Synchronous sampling, single-cycle event pulses
//
// Design decisions made here: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/10ps

module ccl_top
    import ccl_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Classic Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    // Analog comparator core
    input  wire logic        comparator_raw_i,
    output logic             comparator_enable_o,
    output logic             positive_input_select_o,
    output logic [1:0]       negative_input_select_o,
    // Result pin
    output logic             result_output_pin_o,
    output logic             result_output_pin_oe_o,
    // Events
    output logic             event_pulse_o,
    output logic             irq_o
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic [31:0] control_q;
    logic [31:0] control_d;
    logic [31:0] irq_stat_q;
    logic [31:0] irq_stat_d;
    logic [31:0] irq_mask_q;
    logic [31:0] irq_mask_d;
    logic        sync1_q;
    logic        sync2_q;
    logic        result_q;
    logic        ack_q;
    logic [31:0] rdata_q;
    logic        result_presented;
    logic        edge_event;
    logic        bus_req;
    logic        wr_stb;
    logic        hit_control;
    logic        hit_stat;
    logic        hit_mask;
    logic [31:0] byte_mask;
    logic [31:0] control_rd;
    logic [31:0] rdata_d;

    // Expand the byte selects into a bit mask.
    function automatic logic [31:0] sel_to_mask(input logic [3:0] sel);
        logic [31:0] m;
        m = 32'h0000_0000;
        for (int i = 0; i < 4; i++) begin
            m[i*8 +: 8] = {8{sel[i]}};
        end
        return m;
    endfunction

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    // A request is answered once; ack_q blocks the repeat in the ack cycle.
    assign bus_req     = wb_cyc_i & wb_stb_i & ~ack_q;
    assign wr_stb      = bus_req & wb_we_i;
    assign hit_control = (wb_adr_i == CCL_OFS_CONTROL);
    assign hit_stat    = (wb_adr_i == CCL_OFS_IRQ_STAT);
    assign hit_mask    = (wb_adr_i == CCL_OFS_IRQ_MASK);
    assign byte_mask   = sel_to_mask(wb_sel_i);

    // ------------------------------------------------------------------
    // Comparator result path
    // ------------------------------------------------------------------
    // Disabled comparator is treated as a low output; inversion still applies.
    assign result_presented = result_q ^ control_q[CCL_BIT_INVERT];    // see [R3] see [R6]

    // Reads merge the live result into the stored fields; others read zero.
    assign control_rd = (control_q & CCL_CONTROL_WMASK)                 // see [R9]
                      | ({31'h0000_0000, result_presented} << CCL_BIT_RESULT);  // see [R4]

    // ------------------------------------------------------------------
    // Register next values
    // ------------------------------------------------------------------
    // Only writable bits change; the enable bit leaves the other fields alone.
    assign control_d = (wr_stb && hit_control)
                     ? ((control_q & ~(byte_mask & CCL_CONTROL_WMASK))
                        | (wb_dat_i & byte_mask & CCL_CONTROL_WMASK))   // see [R1] see [R9]
                     : control_q;

    // Write one clears; a simultaneous event wins over the clear.
    assign irq_stat_d = ((wr_stb && hit_stat)
                         ? (irq_stat_q & ~(wb_dat_i & byte_mask & CCL_IRQ_WMASK))
                         : irq_stat_q)
                      | ({31'h0000_0000, edge_event} << CCL_BIT_IRQ_EDGE);

    assign irq_mask_d = (wr_stb && hit_mask)
                      ? ((irq_mask_q & ~(byte_mask & CCL_IRQ_WMASK))
                         | (wb_dat_i & byte_mask & CCL_IRQ_WMASK))
                      : irq_mask_q;

    // Unmapped addresses read zero and still get an ack.
    assign rdata_d = hit_control ? control_rd :
                     hit_stat    ? irq_stat_q :
                     hit_mask    ? irq_mask_q : 32'h0000_0000;

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            control_q  <= CCL_CONTROL_RESET;
            irq_stat_q <= CCL_IRQ_RESET;
            irq_mask_q <= CCL_IRQ_RESET;
        end else begin
            control_q  <= control_d;
            irq_stat_q <= irq_stat_d;
            irq_mask_q <= irq_mask_d;
        end
    end

    // Bus answer registers: one cycle of latency after a request is seen.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q   <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            ack_q   <= bus_req;
            rdata_q <= bus_req ? rdata_d : rdata_q;
        end
    end

    // The analog output is asynchronous, so it passes two flip-flops first.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync1_q  <= 1'b0;
            sync2_q  <= 1'b0;
            result_q <= 1'b0;
        end else begin
            sync1_q  <= comparator_raw_i;
            sync2_q  <= sync1_q;
            result_q <= sync2_q & control_q[CCL_BIT_ENABLE];           // see [R11]
        end
    end

    // ------------------------------------------------------------------
    // Event detection
    // ------------------------------------------------------------------
    ccl_edge_detect u_edge (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .level_i    (result_presented),                                 // see [R6]
        .edge_sel_i (control_q[CCL_BIT_EDGE_HI:CCL_BIT_EDGE_LO]),       // see [R5]
        .event_o    (edge_event)
    );

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign wb_dat_o                = rdata_q;
    assign wb_ack_o                = ack_q;
    assign comparator_enable_o     = control_q[CCL_BIT_ENABLE];         // see [R1]
    assign positive_input_select_o = control_q[CCL_BIT_POS_SEL];        // see [R7]
    assign negative_input_select_o = control_q[CCL_BIT_NEG_HI:CCL_BIT_NEG_LO];  // see [R8]
    // The pin is left undriven, not driven low, when drive is off.
    assign result_output_pin_oe_o  = control_q[CCL_BIT_PIN_DRIVE];      // see [R2]
    assign result_output_pin_o     = result_presented & control_q[CCL_BIT_PIN_DRIVE];
    assign event_pulse_o           = edge_event;                        // see [R11]
    assign irq_o                   = |(irq_stat_q & irq_mask_q);

endmodule

// ---- tb/ccl_properties.sv ----
// Port checker of the comparator control block.
`timescale 1ns/10ps

module ccl_properties
    import ccl_pkg::*;
(
    // Bus and pins watched
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        comparator_enable_o,
    input wire logic        positive_input_select_o,
    input wire logic [1:0]  negative_input_select_o,
    input wire logic        result_output_pin_o,
    input wire logic        result_output_pin_oe_o,
    input wire logic        event_pulse_o,
    input wire logic        irq_o
);
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Accepted requests; ack low keeps a held request from counting twice.
    wire logic take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire logic wr_c = take && wb_we_i && wb_adr_i == CCL_OFS_CONTROL;
    wire logic rd   = take && !wb_we_i;

    a_ack_follows: assert property (take |=> wb_ack_o) else $error("ack missing");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    a_enable_write:
        assert property (wr_c && wb_sel_i[1] |=> comparator_enable_o == $past(wb_dat_i[15]))
        else $error("enable not taken");
    a_drive_write:
        assert property (wr_c && wb_sel_i[1] |=> result_output_pin_oe_o == $past(wb_dat_i[14]))
        else $error("drive enable not taken");
    a_pos_select:
        assert property (wr_c && wb_sel_i[0] |=> positive_input_select_o == $past(wb_dat_i[4]))
        else $error("positive select not taken");
    a_neg_select:
        assert property (wr_c && wb_sel_i[0] |=> negative_input_select_o == $past(wb_dat_i[1:0]))
        else $error("negative select not taken");
    a_pin_released:
        assert property (!result_output_pin_oe_o |-> !result_output_pin_o) else $error("pin driven");
    a_reserved_zero:
        assert property (rd && wb_adr_i == CCL_OFS_CONTROL |=>
            (wb_dat_o & ~(CCL_CONTROL_WMASK | 32'h0000_0100)) == 32'h0000_0000)
        else $error("reserved bits set");
    a_unmapped_zero: assert property (rd && wb_adr_i > CCL_OFS_IRQ_MASK |=> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    c_write: cover property (wr_c);
    c_event: cover property (event_pulse_o);
    c_irq: cover property (irq_o);
endmodule

// ---- tb/ccl_comparator_model.sv ----
// Behavioural model of the analog comparator core and its input selectors.
`timescale 1ns/10ps

module ccl_comparator_model (
    // Clock, selection and source levels: pin a, reference, b, c, d, band-gap
    input  wire logic       clk_i,
    input  wire logic       enable_i,
    input  wire logic       pos_sel_i,
    input  wire logic [1:0] neg_sel_i,
    input  wire logic [5:0] level_i,
    // Raw comparator output
    output logic            raw_o
);
    // ----------------------------------------------------------------
    // Core
    // ----------------------------------------------------------------
    logic       noise_q = 1'b0;
    wire  logic pos_w = pos_sel_i ? level_i[1] : level_i[0];
    wire  logic neg_w = level_i[2 + neg_sel_i];
    // A powered-down core gives no usable level, so it chatters to expose leaks.
    always @(posedge clk_i) begin
        noise_q <= ~noise_q;
    end
    assign raw_o = enable_i ? (pos_w & ~neg_w) : noise_q;
endmodule

// ---- tb/ccl_top_test.sv ----
// Self-checking bench of the comparator control block.
`timescale 1ns/10ps

module ccl_top_test;
    import ccl_pkg::*;
    // ----------------------------------------------------------------
    // Stimulus and results
    // ----------------------------------------------------------------
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc   = 1'b0;
    logic        we    = 1'b0;
    logic [7:0]  adr   = 8'h00;
    logic [31:0] wdat  = 32'h0000_0000;
    logic [3:0]  sel   = 4'h0;
    logic [3:0]  bsel  = 4'hf;
    logic [5:0]  lv    = 6'h00;
    logic [31:0] rdat;
    logic [31:0] ctl;
    logic        e;
    wire  logic [31:0] dat_o;
    wire  logic [1:0]  neg;
    wire  logic        ack, en, pos, pin, oe, evt, irq, raw;
    integer      seed = 62918;
    int          miscompares = 0;
    int          n_checks = 0;
    int          pulses = 0;

    ccl_top ccl_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .comparator_raw_i(raw), .comparator_enable_o(en),
        .positive_input_select_o(pos), .negative_input_select_o(neg),
        .result_output_pin_o(pin), .result_output_pin_oe_o(oe), .event_pulse_o(evt), .irq_o(irq));
    ccl_comparator_model ccl_comparator_model_i (.clk_i(clk_i), .enable_i(en), .pos_sel_i(pos),
        .neg_sel_i(neg), .level_i(lv), .raw_o(raw));

    // Clock and event counter.
    initial forever #5 clk_i = ~clk_i;
    always @(posedge clk_i) if (evt === 1'b1) pulses <= pulses + 1;

    // Presented result predicted from the control word and source levels.
    function automatic logic exp_out(input logic [31:0] c, input logic [5:0] l);
        logic p;
        p = c[4] ? l[1] : l[0];
        return (c[15] & p & ~l[2 + c[1:0]]) ^ c[13];
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // One classic cycle; the idle cycle after it also keeps software off a fresh disable.
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        sel  <= bsel;
        @(posedge clk_i);
        while (ack !== 1'b1) @(posedge clk_i);
        rdat = dat_o;
        cyc <= 1'b0;
    endtask

    task automatic chk_rd(input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0000_0000);
        chk(rdat, exp);
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        #100000;
        miscompares++;
        final_report();
    end

    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        chk_rd(CCL_OFS_CONTROL, CCL_CONTROL_RESET);
        chk_rd(CCL_OFS_IRQ_MASK, CCL_IRQ_RESET);
        wb(1'b1, 8'h0c, 32'hffff_ffff);
        chk_rd(8'h0c, 32'h0000_0000);
        // Random control words; all ones and all zeros first.
        for (int i = 0; i < 24; i++) begin
            ctl = (i == 0) ? 32'hffff_ffff : (i == 1) ? 32'h0000_0000 : $random(seed);
            lv <= 6'($random(seed));
            wb(1'b1, CCL_OFS_CONTROL, ctl);
            repeat (5) @(posedge clk_i);
            chk({31'h0, pin}, {31'h0, ctl[14] & exp_out(ctl, lv)});
            chk({31'h0, oe}, {31'h0, ctl[14]});
            chk_rd(CCL_OFS_CONTROL, (ctl & CCL_CONTROL_WMASK) | {23'h0, exp_out(ctl, lv), 8'h00});
        end
        // Clearing byte 1 alone turns the core off and leaves the low fields as they were.
        bsel = 4'h2;
        wb(1'b1, CCL_OFS_CONTROL, 32'h0000_0000);
        bsel = 4'hf;
        chk_rd(CCL_OFS_CONTROL, ctl & CCL_CONTROL_WMASK & 32'h0000_00ff);
        // Every edge mode with and without invert, on a rising pin a.
        for (int m = 0; m < 8; m++) begin
            lv <= 6'h00;
            e = m[2] ? m[1] : m[0];
            wb(1'b1, CCL_OFS_IRQ_MASK, {31'h0, m[1]});
            wb(1'b1, CCL_OFS_CONTROL, {16'h0, 2'b10, m[2], 5'h0, m[1:0], 6'h00});
            repeat (6) @(posedge clk_i);
            wb(1'b1, CCL_OFS_IRQ_STAT, 32'h0000_0001);
            pulses = 0;
            lv <= 6'h01;
            repeat (6) @(posedge clk_i);
            chk(pulses, {31'h0, e});
            chk({31'h0, irq}, {31'h0, e & m[1]});
            chk_rd(CCL_OFS_IRQ_STAT, {31'h0, e});
            wb(1'b1, CCL_OFS_IRQ_STAT, 32'h0000_0001);
            @(posedge clk_i);
            chk({31'h0, irq}, 32'h0000_0000);
        end
        final_report();
    end
endmodule

bind ccl_top ccl_properties ccl_properties_i (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .comparator_enable_o(comparator_enable_o), .positive_input_select_o(positive_input_select_o),
    .negative_input_select_o(negative_input_select_o), .result_output_pin_o(result_output_pin_o),
    .result_output_pin_oe_o(result_output_pin_oe_o), .event_pulse_o(event_pulse_o), .irq_o(irq_o));
